//--- src/lba_bus.sv
// Purpose: Address phase, strobes and burst sequencing of the local bus.
// Assumes: mclk is the double-rate input clock; inputs are synchronous.
// Notes: Bus states last two mclk cycles; ready is sampled at their end.
`default_nettype none
module lba_bus #(
	parameter int DEPTH = lba_pkg::LBA_FIFO_DEPTH
) (
	// Double-rate clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Transfer requests from the core.
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [lba_pkg::LBA_ADDR_W-1:0] req_addr,
	input wire logic [lba_pkg::LBA_SIZE_W-1:0] req_size,
	input wire logic req_write,
	// Write data stream from the core.
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [lba_pkg::LBA_DATA_W-1:0] wr_data,
	// Read data returned to the core.
	output logic rd_valid,
	output logic [lba_pkg::LBA_DATA_W-1:0] rd_data,
	// Shared address/data lines, split into three signals.
	input wire logic [lba_pkg::LBA_DATA_W-1:0] muxed_addr_data_lines_in,
	output logic [lba_pkg::LBA_DATA_W-1:0] muxed_addr_data_lines_out,
	output logic muxed_addr_data_lines_oe,
	// Bus strobes and transceiver control.
	output logic addr_latch_n_out,
	output logic addr_latch_n_oe,
	output logic addr_phase_status_n,
	output logic write_read,
	output logic xcvr_direction,
	output logic xcvr_enable_n,
	input wire logic ready,
	// Bus hold arbitration.
	input wire logic hold_req,
	output logic hold_ack,
	// Processor clock phase for the core.
	output logic proc_clk
);
	localparam int DW = lba_pkg::LBA_DATA_W;
	localparam int SW = lba_pkg::LBA_SIZE_W;
	localparam int LW = $clog2(DEPTH+1);

	// A burst of four words must fit in the buffer.
	if (DEPTH < (1 << SW)) begin : g_chk
		$error("lba_bus buffer depth below the longest burst");
	end

	// Half-cycle phase; high marks the second half of a bus state.
	logic phase_r;
	// Current bus state.
	lba_pkg::lba_state_e state_r;
	// Words still to go after the current one.
	logic [SW-1:0] cnt_r;
	// Size code of the current transaction.
	logic [SW-1:0] size_r;
	// Latched write indication.
	logic write_r;
	// Previous data state ended with ready and more words follow.
	logic again_r;
	// Line output register.
	logic [DW-1:0] lad_r;
	// Read data return registers.
	logic rd_valid_r;
	logic [DW-1:0] rd_data_r;
	// End of a bus state.
	logic tick;
	// Request is taken now.
	logic take;
	// A data state completes with ready.
	logic done;

	// Buffer for write data.
	lba_fifo_if #(.W(DW), .D(DEPTH)) wq ();
	lba_fifo #(.W(DW), .D(DEPTH)) u_fifo (
		.mclk(mclk),
		.reset(reset),
		.f(wq.fifo)
	);
	assign wq.in_valid = wr_valid;
	assign wq.in_data = wr_data;
	assign wr_ready = wq.in_ready;

	assign tick = phase_r;
	assign done = tick && state_r == lba_pkg::LBA_DATA && ready;
	// A write is only taken once its whole burst is buffered.
	assign take = tick && state_r == lba_pkg::LBA_IDLE && !hold_req
		&& req_valid
		&& (!req_write || wq.level > LW'(req_size));
	assign req_ready = take;
	// Pop a word as it is loaded onto the lines.
	assign wq.out_ready = tick && write_r
		&& (state_r == lba_pkg::LBA_ADDR
		|| (done && cnt_r != '0));

	// Divide the input clock by two.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			phase_r <= lba_pkg::LBA_PHASE_RST;
		end else begin
			phase_r <= !phase_r;
		end
	end
	assign proc_clk = phase_r;

	// Bus state sequencing; hold wins over a new request.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_r <= lba_pkg::LBA_IDLE;
		end else if (tick) begin
			case (state_r)
				lba_pkg::LBA_IDLE: begin
					if (hold_req) begin
						state_r <= lba_pkg::LBA_HOLD;
					end else if (take) begin
						state_r <= lba_pkg::LBA_ADDR;
					end
				end
				lba_pkg::LBA_ADDR: begin
					state_r <= lba_pkg::LBA_DATA;
				end
				lba_pkg::LBA_DATA: begin
					// Without ready the state repeats as a wait state.
					if (ready && cnt_r == '0) begin
						state_r <= lba_pkg::LBA_IDLE;
					end
				end
				default: begin
					if (!hold_req) begin
						state_r <= lba_pkg::LBA_IDLE;
					end
				end
			endcase
		end
	end

	// Transaction attributes are caught as the request is taken.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			size_r <= lba_pkg::LBA_CNT_RST;
			write_r <= 1'b0;
		end else if (take) begin
			size_r <= req_size;
			write_r <= req_write;
		end
	end

	// Remaining-word counter of the burst.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_r <= lba_pkg::LBA_CNT_RST;
		end else if (take) begin
			cnt_r <= req_size;
		end else if (done && cnt_r != '0) begin
			cnt_r <= cnt_r - SW'(1);
		end
	end

	// Marks the data state after a completed word of a burst.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			again_r <= 1'b0;
		end else if (tick) begin
			again_r <= done && cnt_r != '0;
		end
	end

	// Line output register: address then write words.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lad_r <= lba_pkg::LBA_LAD_RST;
		end else if (take) begin
			lad_r <= {req_addr, req_size};
		end else if (wq.out_ready) begin
			lad_r <= wq.out_data;
		end
	end

	// Read words are captured at the end of each ready data state.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_valid_r <= 1'b0;
			rd_data_r <= lba_pkg::LBA_LAD_RST;
		end else begin
			rd_valid_r <= done && !write_r;
			if (done && !write_r) begin
				rd_data_r <= muxed_addr_data_lines_in;
			end
		end
	end
	assign rd_valid = rd_valid_r;
	assign rd_data = rd_data_r;

	// Pin drive derived from the bus state.
	assign muxed_addr_data_lines_out = lad_r;
	assign muxed_addr_data_lines_oe = state_r == lba_pkg::LBA_ADDR
		|| (state_r == lba_pkg::LBA_DATA && write_r);
	// Latch strobe only in the first half of the address state.
	assign addr_latch_n_out = !(state_r == lba_pkg::LBA_ADDR
		&& !phase_r);
	assign addr_latch_n_oe = state_r != lba_pkg::LBA_HOLD;
	assign addr_phase_status_n = !(state_r == lba_pkg::LBA_ADDR
		|| (state_r == lba_pkg::LBA_DATA && again_r));
	assign write_read = write_r;
	// Direction only changes when a new request is taken in idle.
	assign xcvr_direction = write_r;
	assign xcvr_enable_n = state_r != lba_pkg::LBA_DATA;
	assign hold_ack = state_r == lba_pkg::LBA_HOLD;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	// The phase alternates on every input clock edge; the first edge
	// after reset is skipped because the phase was frozen before it.
	a_clock_halves: assert property (!$past(reset) |->
		phase_r != $past(phase_r))
		else $error("processor clock phase did not toggle");
	// The address state drives address and size on the lines.
	a_addr_drive: assert property (state_r == lba_pkg::LBA_ADDR |->
		muxed_addr_data_lines_oe
		&& muxed_addr_data_lines_out[SW-1:0] == size_r)
		else $error("address state lines wrong");
	// Write data is driven through the data state.
	a_write_drive: assert property (state_r == lba_pkg::LBA_DATA
		&& write_r |-> muxed_addr_data_lines_oe)
		else $error("write data not driven");
	// The lines float in idle, hold and read data states.
	a_lines_float: assert property (state_r != lba_pkg::LBA_ADDR
		&& !(state_r == lba_pkg::LBA_DATA && write_r)
		|-> !muxed_addr_data_lines_oe)
		else $error("lines driven while not needed");
	// The latch strobe falls then rises within the address state.
	a_latch_pulse: assert property (state_r == lba_pkg::LBA_ADDR
		&& !phase_r |-> !addr_latch_n_out ##1 addr_latch_n_out)
		else $error("latch strobe shape wrong");
	// The latch strobe floats in hold.
	a_latch_float: assert property (hold_ack |-> !addr_latch_n_oe)
		else $error("latch strobe driven in hold");
	// Status strobe off in the first data state.
	a_status_first: assert property (state_r == lba_pkg::LBA_ADDR
		&& phase_r |=> addr_phase_status_n [*2])
		else $error("status strobe stuck after address");
	// A ready with words left brings the status strobe back.
	a_status_burst: assert property (done && cnt_r != '0
		|=> !addr_phase_status_n [*2])
		else $error("burst status strobe missing");
	// Missing ready gives a wait state without status strobe.
	a_wait_state: assert property (tick && state_r == lba_pkg::LBA_DATA
		&& !ready |=> state_r == lba_pkg::LBA_DATA
		&& addr_phase_status_n)
		else $error("wait state wrong");
	// A burst never has more words than its size code allows.
	a_burst_len: assert property (state_r == lba_pkg::LBA_DATA
		|-> cnt_r <= size_r)
		else $error("burst counter beyond size code");
	// Write indication holds through the data states.
	a_wr_hold: assert property (state_r == lba_pkg::LBA_DATA
		|-> $stable(write_read))
		else $error("write indication changed in data");
	// Direction never moves while the transceiver is enabled.
	a_dir_stable: assert property (!xcvr_enable_n
		&& $past(!xcvr_enable_n) |-> $stable(xcvr_direction))
		else $error("direction changed while enabled");
	// Transceiver enable covers both cycles of the first data state.
	a_xcvr_enable: assert property ($rose(state_r == lba_pkg::LBA_DATA)
		|-> !xcvr_enable_n [*2])
		else $error("transceiver enable missing");
endmodule
`default_nettype wire

//--- src/lba_fifo.sv
// Purpose: Write data buffer between the user port and the bus engine.
// Assumes: Depth is a power of two of at least two.
// Notes: Full and empty are exact; a pop and a push may share a cycle.
`default_nettype none
module lba_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Both sides of the buffer.
	lba_fifo_if.fifo f
);
	localparam int AW = $clog2(D);
	localparam int LW = $clog2(D+1);

	// Refuse shapes the pointer wrap cannot serve.
	if (D < 2 || (1 << AW) != D) begin : g_chk
		$error("lba_fifo depth must be a power of two, at least two");
	end

	// Storage array, one entry per word.
	logic [W-1:0] mem [D];
	// Read and write pointers, and fill level.
	logic [AW-1:0] rd_ptr_r;
	logic [AW-1:0] wr_ptr_r;
	logic [LW-1:0] level_r;
	// Accepted push and pop this cycle.
	logic push;
	logic pop;

	assign f.in_ready = level_r != LW'(D);
	assign f.out_valid = level_r != '0;
	assign f.out_data = mem[rd_ptr_r];
	assign f.level = level_r;
	assign push = f.in_valid && f.in_ready;
	assign pop = f.out_ready && f.out_valid;

	// Storage is written without reset; only the pointers and level need it.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_r] <= f.in_data;
		end
	end

	// Pointers and level move with each accepted transfer.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_ptr_r <= '0;
			wr_ptr_r <= '0;
			level_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + AW'(1);
			end
			if (push && !pop) begin
				level_r <= level_r + LW'(1);
			end else if (pop && !push) begin
				level_r <= level_r - LW'(1);
			end
		end
	end
endmodule
`default_nettype wire

//--- src/lba_fifo_if.sv
// Purpose: Carrier of the write data stream into and out of the buffer.
// Assumes: Valid and ready handshake on both sides, same clock.
// Notes: The fill level is exported so the bus side can plan bursts.
`default_nettype none
interface lba_fifo_if #(
	parameter int W = 32,
	parameter int D = 8
);
	// Filling side.
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	// Draining side.
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	// Number of words held.
	logic [$clog2(D+1)-1:0] level;
	modport fifo (input in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data, level);
	modport drain (output out_ready,
		input out_valid, out_data, level);
endinterface
`default_nettype wire

//--- src/lba_pkg.sv
// Purpose: Shared constants and types of the local bus address-phase block.
// Assumes: One clock, the double-rate bus clock, at 100 MHz.
// Notes: Every number used by more than one design file lives here.
`default_nettype none
package lba_pkg;
	// Width of the shared address/data lines.
	localparam int LBA_DATA_W = 32;
	// Position and width of the size code on the low lines.
	localparam int LBA_SIZE_LSB = 0;
	localparam int LBA_SIZE_W = 2;
	// Lowest line that carries the word address.
	localparam int LBA_ADDR_LSB = 2;
	localparam int LBA_ADDR_W = LBA_DATA_W - LBA_ADDR_LSB;
	// Divide ratio from the input clock to the processor clock.
	localparam int LBA_CLK_DIV = 2;
	// Input clock period in ns, and processor clock period derived from it.
	localparam int LBA_MCLK_NS = 10;
	localparam int LBA_PCLK_NS = LBA_MCLK_NS * LBA_CLK_DIV;
	// Depth of the write data buffer.
	localparam int LBA_FIFO_DEPTH = 8;
	// Reset value of the half-cycle phase flop.
	localparam logic LBA_PHASE_RST = 1'b0;
	// Reset value of the remaining-word counter.
	localparam logic [LBA_SIZE_W-1:0] LBA_CNT_RST = 2'h0;
	// Reset value of the line output register.
	localparam logic [LBA_DATA_W-1:0] LBA_LAD_RST = 32'h0000_0000;
	// Bus states: idle, address, data (also wait), hold.
	typedef enum logic [1:0] {
		LBA_IDLE = 2'b00,
		LBA_ADDR = 2'b01,
		LBA_DATA = 2'b10,
		LBA_HOLD = 2'b11
	} lba_state_e;
endpackage
`default_nettype wire

//--- verif/lba_bus_bench.sv
// Purpose: Self-checking bench of the local bus address-phase block.
// Assumes: Inputs change on the falling edge of mclk.
// Notes: Each transfer is watched cycle by cycle and counted.
`default_nettype none
module lba_bus_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, reset, req_valid, req_ready, req_write, wr_valid, wr_ready;
	logic rd_valid, lad_oe, latch_n, latch_oe, stat_n, write_read, dir, en_n;
	logic ready, hold_req, hold_ack, proc_clk;
	logic [29:0] req_addr;
	logic [1:0] req_size;
	logic [31:0] wr_data, rd_data, lad_in, lad_out;
	int waits, n_errors, checks_done;
	logic [31:0] exp_w[$]; // Pushed words not yet seen on the bus.
	lba_bus DUT (.mclk, .reset, .req_valid, .req_ready, .req_addr, .req_size,
		.req_write, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data,
		.muxed_addr_data_lines_in(lad_in), .muxed_addr_data_lines_out(lad_out),
		.muxed_addr_data_lines_oe(lad_oe), .addr_latch_n_out(latch_n),
		.addr_latch_n_oe(latch_oe), .addr_phase_status_n(stat_n), .write_read,
		.xcvr_direction(dir), .xcvr_enable_n(en_n), .ready, .hold_req,
		.hold_ack, .proc_clk);
	lba_mem_model mem (.mclk, .proc_clk, .lad_out, .lad_oe, .latch_n,
		.wr(write_read), .en_n, .waits, .lad_in, .ready);
	// Compare a value from the block.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	// Compare a count of observed cycles or words.
	task automatic cnt(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			n_errors++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	// Print the counts and the verdict, then stop.
	task automatic end_sim();
		$display("Errors %0d, checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// A bounded wait ran out.
	task automatic fail_wait();
		n_errors++;
		$display("[ERR] %0t wait ran out", $time);
		end_sim();
	endtask
	// Offer one word to the buffer; valid stays up for the caller.
	task automatic push(input logic [31:0] w);
		int i;
		wr_data = w;
		wr_valid = 1'h1;
		for (i = 0; i < 50 && !wr_ready; i++)
			@(negedge mclk);
		if (!wr_ready)
			fail_wait();
		exp_w.push_back(w);
		@(negedge mclk);
	endtask
	// Run one transfer and judge every cycle of it.
	task automatic xfer(input logic [29:0] a, input logic [1:0] s,
		input logic w, input int nw);
		int i, st, en, lt, dc, rv, bad;
		st = 0;
		en = 0;
		lt = 0;
		dc = 0;
		rv = 0;
		bad = 0;
		waits = nw;
		req_addr = a;
		req_size = s;
		req_write = w;
		req_valid = 1'h1;
		#1;
		for (i = 0; i < 50 && !req_ready; i++) begin
			@(negedge mclk);
			#1;
		end
		if (!req_ready)
			fail_wait();
		@(negedge mclk);
		req_valid = 1'h0;
		chk(lad_out, {a, s});
		chk(lad_oe, 1'h1);
		chk(write_read, w);
		for (i = 0; i < 400; i++) begin
			st += !stat_n;
			en += !en_n;
			lt += !latch_n;
			dc += !en_n && dir !== w;
			bad += lad_oe && !en_n && !w;
			if (rd_valid) begin
				chk(rd_data, {a, 2'h0} ^ rv ^ 32'h5A5A_5A5A);
				rv++;
			end
			if (en > 0 && en_n)
				break;
			@(negedge mclk);
		end
		if (i == 400)
			fail_wait();
		cnt(st, 2 + 2 * s);
		cnt(en, 2 * (s + 1) * (nw + 1));
		cnt(lt, 1);
		cnt(dc, 0);
		cnt(bad, 0);
		chk(lad_oe, 1'h0);
		cnt(mem.idx, s + 1);
		if (w)
			for (i = 0; i <= s; i++)
				chk(mem.wq.pop_front(), exp_w.pop_front());
		else
			cnt(rv, s + 1);
	endtask
	// The processor clock toggles on every input clock.
	task automatic t_reset();
		int i;
		logic p;
		p = proc_clk;
		for (i = 0; i < 4; i++) begin
			@(negedge mclk);
			chk(proc_clk, !p);
			p = proc_clk;
		end
		chk(lad_oe, 1'h0);
	endtask
	// Single-word write then reads of every burst size, back to back.
	task automatic t_single();
		push(32'hCAFE_0001);
		wr_valid = 1'h0;
		xfer(30'h0000_1234, 2'h0, 1'h1, 0);
		xfer(30'h0ABC_DEF0, 2'h0, 1'h0, 1);
		xfer(30'h3FFF_FFFC, 2'h3, 1'h0, 0);
		xfer(30'h0000_0040, 2'h2, 1'h0, 1);
		xfer(30'h1555_5555, 2'h1, 1'h0, 2);
	endtask
	// Fill the buffer until it refuses, then drain it by three writes, two of them with wait states.
	task automatic t_fill();
		int i;
		for (i = 0; i < 8; i++)
			push(32'hD000_0000 + i);
		chk(wr_ready, 1'h0);
		wr_valid = 1'h0;
		xfer(30'h0000_0100, 2'h3, 1'h1, 2);
		xfer(30'h0000_0200, 2'h2, 1'h1, 0);
		xfer(30'h0000_0300, 2'h0, 1'h1, 1);
		chk(wr_ready, 1'h1);
	endtask
	// Hold state floats the latch strobe and refuses requests.
	task automatic t_hold();
		int i;
		hold_req = 1'h1;
		for (i = 0; i < 20 && !hold_ack; i++)
			@(negedge mclk);
		chk(hold_ack, 1'h1);
		chk(latch_oe, 1'h0);
		req_valid = 1'h1;
		for (i = 0; i < 4; i++) begin
			@(negedge mclk);
			chk(req_ready, 1'h0);
		end
		req_valid = 1'h0;
		hold_req = 1'h0;
		for (i = 0; i < 20 && hold_ack; i++)
			@(negedge mclk);
		chk(latch_oe, 1'h1);
		xfer(30'h0000_0777, 2'h1, 1'h0, 0);
	endtask
	// Free-running input clock.
	initial begin
		mclk = 1'h0;
		forever
			#5 mclk = ~mclk;
	end
	// Main sequence.
	initial begin
		reset = 1'h1;
		req_valid = 1'h0;
		req_addr = 30'h0;
		req_size = 2'h0;
		req_write = 1'h0;
		wr_valid = 1'h0;
		wr_data = 32'h0;
		hold_req = 1'h0;
		waits = 0;
		n_errors = 0;
		checks_done = 0;
		repeat (6) @(negedge mclk);
		reset = 1'h0;
		t_reset();
		t_single();
		t_fill();
		t_hold();
		end_sim();
	end
endmodule
`default_nettype wire

//--- verif/lba_mem_model.sv
// Purpose: Memory side of the local bus, answering the block's transfers.
// Assumes: Bus states end on mclk edges where proc_clk is high.
// Notes: Lines not driven by this side show the inverse of their last value.
`default_nettype none
module lba_mem_model (
	// Clock and bus view.
	input wire logic mclk,
	input wire logic proc_clk,
	input wire logic [31:0] lad_out,
	input wire logic lad_oe,
	input wire logic latch_n,
	input wire logic wr,
	input wire logic en_n,
	// Wait states to insert before each word.
	input wire logic [31:0] waits,
	// Answers to the block.
	output logic [31:0] lad_in,
	output logic ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [29:0] addr_r; // Captured word address.
	logic [1:0] size_r; // Captured size code.
	logic wr_r; // Captured write flag.
	int idx; // Words finished in this transfer.
	int wcnt; // Waits given to the current word.
	logic [31:0] wq[$]; // Words written by the block.
	// Start from a quiet bus.
	initial begin
		ready = 1'h0;
		lad_in = 32'h0;
		wr_r = 1'h0;
		idx = 0;
		wcnt = 0;
	end
	// Capture the address state and count finished data states.
	always @(posedge mclk) begin
		if (!latch_n && lad_oe) begin
			addr_r <= lad_out[31:2];
			size_r <= lad_out[1:0];
			wr_r <= wr;
			idx <= 0;
			wcnt <= 0;
		end else if (proc_clk && !en_n) begin
			// A ready edge closes a word, otherwise a wait follows.
			if (ready) begin
				if (wr_r)
					wq.push_back(lad_out);
				idx <= idx + 1;
				wcnt <= 0;
			end else begin
				wcnt <= wcnt + 1;
			end
		end
	end
	// Drive ready and read data away from the sampling edge.
	always @(negedge mclk) begin
		ready <= !en_n && proc_clk && wcnt == waits;
		if (!en_n && !wr_r)
			lad_in <= {addr_r, 2'h0} ^ idx ^ 32'h5A5A_5A5A;
		else
			lad_in <= ~lad_in;
	end
endmodule
`default_nettype wire
